// ===== logic/mbf_map.svh
/*
  constants of the modbus function handler: codes, limits, counter slots.
  assumes inclusion by bare name from every design file that needs them.
*/
`ifndef MBF_MAP_SVH
`define MBF_MAP_SVH

`define MBF_FC_RD_HOLD 8'h03
`define MBF_FC_RD_INPUT 8'h04
`define MBF_FC_WR_SINGLE 8'h06
`define MBF_FC_DIAG 8'h08
`define MBF_FC_DUMP_DICT 8'h65
`define MBF_FC_DUMP_ARRAY 8'h66
`define MBF_SUB_CLEAR 16'h000a
`define MBF_SUB_FIRST 16'h000b
`define MBF_SUB_LAST 16'h0012
`define MBF_SUB_START 8'h55
`define MBF_SUB_NEXT 8'haa
`define MBF_EXC_FLAG 8'h80
`define MBF_EXC_FUNC 8'h01
`define MBF_EXC_ADDR 8'h02
`define MBF_EXC_VALUE 8'h03
`define MBF_EXC_BUSY 8'h06
`define MBF_EXC_NAK 8'h07
`define MBF_RD_MAX 16'h007d
`define MBF_BCAST 8'h00
`define MBF_REQ_LEN 8'h08
`define MBF_MIN_LEN 8'h04
`define MBF_PDO_BASE 16'h1000
`define MBF_CRC_INIT 16'hffff
`define MBF_CRC_POLY 16'ha001
`define MBF_CNT_BUS 0
`define MBF_CNT_COMM 1
`define MBF_CNT_EXC 2
`define MBF_CNT_SERVER 3
`define MBF_CNT_NORESP 4
`define MBF_CNT_NAK 5
`define MBF_CNT_BUSY 6
`define MBF_CNT_OVERRUN 7
`define MBF_NUM_CNT 8

`endif

// ===== logic/mbf_pkg.sv
/*
  types of the modbus function handler: state, reply kinds, byte and
  dictionary carriers. assumes nothing of its surroundings.
*/
package mbf_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RECV = 6'h02,
    ST_CHECK = 6'h04,
    ST_EXEC = 6'h08,
    ST_OD_WAIT = 6'h10,
    ST_SEND = 6'h20
  } mbf_state_t;

  typedef enum logic [2:0] {
    K_READ = 3'h0,
    K_ECHO = 3'h1,
    K_DIAG = 3'h2,
    K_EXC = 3'h3,
    K_DUMP = 3'h4
  } mbf_kind_t;

  typedef enum logic [1:0] {
    OD_READ = 2'h0,
    OD_WRITE = 2'h1,
    OD_SEG_OPEN = 2'h2,
    OD_SEG_BYTE = 2'h3
  } mbf_od_op_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic frame_end;
    logic overrun;
  } mbf_rx_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } mbf_tx_t;

  typedef struct packed {
    logic valid;
    mbf_od_op_t op;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbf_od_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] exc;
    logic [15:0] rdata;
  } mbf_od_rsp_t;

endpackage

// ===== logic/mbf_crc16.sv
/*
  running modbus crc over a byte stream, held in a register.
  assumes bytes and init come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "mbf_map.svh"

module mbf_crc16 (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // byte stream
  input wire logic i_init,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  // result
  output logic [15:0] o_crc
);

  logic [15:0] next_crc;

  always_comb begin
    next_crc = o_crc ^ {8'h00, i_byte};
    for (int b = 0; b < 8; b++) begin
      if (next_crc[0]) begin
        next_crc = (next_crc >> 1) ^ `MBF_CRC_POLY;
      end else begin
        next_crc = next_crc >> 1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n || i_init) begin
      o_crc <= `MBF_CRC_INIT;
    end else if (i_valid) begin
      o_crc <= next_crc;
    end
  end

endmodule

// ===== logic/mbf_counter.sv
/*
  one wrapping diagnostic counter; an increment beats a clear.
  assumes strobes from logic on the same clock.
*/
`timescale 1ns/1ps

module mbf_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // strobes
  input wire logic i_clear,
  input wire logic i_inc,
  // value
  output logic [WIDTH-1:0] o_count
);

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_count <= '0;
    end else if (i_inc) begin
      o_count <= i_clear ? WIDTH'(1) : o_count + WIDTH'(1);
    end else if (i_clear) begin
      o_count <= '0;
    end
  end

endmodule

// ===== logic/mbf_function_handler.sv
/*
  modbus rtu server function handler: takes received frame bytes, checks
  crc and address, serves reads, single writes, diagnostics and dictionary
  dumps through a dictionary port, and emits the reply byte stream.
  assumes a framer on the same clock that delivers bytes and a frame-end
  pulse after the inter-frame gap, and a dictionary that answers with ack.
*/
`timescale 1ns/1ps
`include "mbf_map.svh"

// Summary of operation
// - subfunction 0A clears counters and diagnostic register
// - subfunction 0B returns bus message count
// - subfunction 0C returns bus error count
// - subfunction 0D returns exception reply count
// - subfunction 0E returns served message count
// - subfunction 0F returns unanswered message count
// - subfunction 10 returns negative-acknowledge count
// - subfunction 11 returns server-busy count
// - subfunction 12 returns character overrun count
// - code 101 dumps dictionary, start then next
// - code 102 dumps array, start then next
// - codes 03 and 04 read consecutive registers
// - read reply carries byte count twice registers
// - process data reads need 4-byte alignment
// - code 06 writes one 16-bit register
// - single writes go to process data
// - write reply echoes address, value, crc
// - big-endian fields, dump data little-endian
// - eight data bits; stop bits by parity
module mbf_function_handler (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // own station
  input wire logic [7:0] i_station_address_field,
  // received bytes
  input wire mbf_pkg::mbf_rx_t i_rx,
  // reply bytes
  input wire logic i_tx_ready,
  output mbf_pkg::mbf_tx_t o_tx,
  // dictionary port
  input wire mbf_pkg::mbf_od_rsp_t i_od,
  output mbf_pkg::mbf_od_req_t o_od,
  // status
  output logic [15:0] o_diag_register
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_diag_sub(input logic [15:0] sub);
    is_diag_sub = (sub >= `MBF_SUB_CLEAR) && (sub <= `MBF_SUB_LAST);
  endfunction

  function automatic logic is_read_fc(input logic [7:0] fc);
    is_read_fc = (fc == `MBF_FC_RD_HOLD) || (fc == `MBF_FC_RD_INPUT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  mbf_pkg::mbf_state_t state;
  mbf_pkg::mbf_kind_t kind;
  logic [7:0] rx_len;
  logic [5:0][7:0] hdr;
  logic [15:0] word;
  logic word_ok;
  logic first_fetch;
  logic [15:0] fetch_addr;
  logic [8:0] idx;
  logic [8:0] body_len;
  logic [7:0] exc_code;
  logic bcast;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [15:0] cnt [`MBF_NUM_CNT];
  logic [`MBF_NUM_CNT-1:0] cnt_inc;
  logic cnt_clear;

  logic [7:0] fc;
  logic [15:0] w2;
  logic [15:0] w4;
  logic [15:0] sub_off;
  logic tx_free;
  logic in_crc;
  logic need_word;
  logic body_load;
  logic frame_good;
  logic for_us;
  logic exc_start;
  logic [7:0] next_byte;

  assign fc = hdr[1];
  assign w2 = {hdr[2], hdr[3]};
  assign w4 = {hdr[4], hdr[5]};
  assign sub_off = w2 - `MBF_SUB_FIRST;
  assign tx_free = !o_tx.valid || i_tx_ready;
  assign in_crc = (idx >= body_len);
  assign frame_good = (rx_len >= `MBF_MIN_LEN) && (rx_crc == 16'h0000);
  assign for_us = (hdr[0] == i_station_address_field) || (hdr[0] == `MBF_BCAST);

  ////////////////////////////////////////////////////////////////////////
  // crc engines and counters

  mbf_crc16 u_rx_crc (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_init(state == mbf_pkg::ST_CHECK),
    .i_valid(i_rx.valid && (state == mbf_pkg::ST_IDLE || state == mbf_pkg::ST_RECV)),
    .i_byte(i_rx.data),
    .o_crc(rx_crc)
  );

  mbf_crc16 u_tx_crc (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_init(state == mbf_pkg::ST_EXEC),
    .i_valid(body_load),
    .i_byte(next_byte),
    .o_crc(tx_crc)
  );

  generate
    for (genvar g = 0; g < `MBF_NUM_CNT; g++) begin : g_cnt
      mbf_counter #(.WIDTH(16)) u_cnt (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_clear(cnt_clear),
        .i_inc(cnt_inc[g]),
        .o_count(cnt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // counter events

  assign exc_start = (state == mbf_pkg::ST_SEND) && (kind == mbf_pkg::K_EXC) && (idx == 9'h000) && tx_free;
  assign cnt_clear = (state == mbf_pkg::ST_EXEC) && (fc == `MBF_FC_DIAG) && (rx_len == `MBF_REQ_LEN)
                     && (w2 == `MBF_SUB_CLEAR) && (hdr[0] != `MBF_BCAST);

  always_comb begin
    cnt_inc = '0;
    cnt_inc[`MBF_CNT_BUS] = (state == mbf_pkg::ST_CHECK);
    cnt_inc[`MBF_CNT_COMM] = (state == mbf_pkg::ST_CHECK) && !frame_good;
    cnt_inc[`MBF_CNT_SERVER] = (state == mbf_pkg::ST_CHECK) && frame_good && for_us;
    cnt_inc[`MBF_CNT_NORESP] = (state == mbf_pkg::ST_EXEC) && bcast;
    cnt_inc[`MBF_CNT_EXC] = exc_start;
    cnt_inc[`MBF_CNT_NAK] = exc_start && (exc_code == `MBF_EXC_NAK);
    cnt_inc[`MBF_CNT_BUSY] = exc_start && (exc_code == `MBF_EXC_BUSY);
    cnt_inc[`MBF_CNT_OVERRUN] = i_rx.overrun;
  end

  // one sticky bit per exception code sent; a new one beats the clear
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_diag_register <= 16'h0000;
    end else if (exc_start) begin
      o_diag_register <= (cnt_clear ? 16'h0000 : o_diag_register) | (16'h0001 << exc_code[3:0]);
    end else if (cnt_clear) begin
      o_diag_register <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive: header bytes and frame length

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      rx_len <= 8'h00;
      hdr <= '0;
    end else if (state == mbf_pkg::ST_IDLE && i_rx.valid) begin
      rx_len <= 8'h01;
      hdr[0] <= i_rx.data;
    end else if (state == mbf_pkg::ST_RECV && i_rx.valid) begin
      if (rx_len < 8'h06) begin
        hdr[rx_len[2:0]] <= i_rx.data;
      end
      if (rx_len != 8'hff) begin
        rx_len <= rx_len + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reply byte generation

  always_comb begin
    next_byte = 8'h00;
    case (kind)
      mbf_pkg::K_READ: begin
        if (idx == 9'h000) next_byte = hdr[0];
        else if (idx == 9'h001) next_byte = fc;
        else if (idx == 9'h002) next_byte = {w4[6:0], 1'b0};
        else next_byte = idx[0] ? word[15:8] : word[7:0];
      end
      mbf_pkg::K_ECHO: begin
        next_byte = hdr[idx[2:0]];
      end
      mbf_pkg::K_DIAG: begin
        if (idx == 9'h004) next_byte = word[15:8];
        else if (idx == 9'h005) next_byte = word[7:0];
        else next_byte = hdr[idx[2:0]];
      end
      mbf_pkg::K_EXC: begin
        if (idx == 9'h000) next_byte = hdr[0];
        else if (idx == 9'h001) next_byte = fc | `MBF_EXC_FLAG;
        else next_byte = exc_code;
      end
      mbf_pkg::K_DUMP: begin
        if (idx == 9'h000) next_byte = hdr[0];
        else if (idx == 9'h001) next_byte = fc;
        else if (idx == 9'h002) next_byte = hdr[2];
        else if (idx == 9'h003) next_byte = body_len[7:0] - 8'h04;
        else next_byte = word[7:0];
      end
      default: next_byte = 8'h00;
    endcase
  end

  assign need_word = !word_ok && !in_crc &&
                     (((kind == mbf_pkg::K_READ) && (idx >= 9'h003) && idx[0]) ||
                      ((kind == mbf_pkg::K_DUMP) && (idx >= 9'h004)));
  assign body_load = (state == mbf_pkg::ST_SEND) && tx_free && !in_crc && !need_word;

  ////////////////////////////////////////////////////////////////////////
  // control sequence

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state <= mbf_pkg::ST_IDLE;
      kind <= mbf_pkg::K_EXC;
      exc_code <= 8'h00;
      bcast <= 1'b0;
      word <= 16'h0000;
      word_ok <= 1'b0;
      first_fetch <= 1'b0;
      fetch_addr <= 16'h0000;
      idx <= 9'h000;
      body_len <= 9'h000;
      o_od <= '0;
      o_tx <= '0;
    end else begin
      case (state)
        mbf_pkg::ST_IDLE: begin
          if (i_rx.valid) state <= mbf_pkg::ST_RECV;
        end
        mbf_pkg::ST_RECV: begin
          if (i_rx.frame_end) state <= mbf_pkg::ST_CHECK;
        end
        mbf_pkg::ST_CHECK: begin
          bcast <= (hdr[0] == `MBF_BCAST);
          state <= (frame_good && for_us) ? mbf_pkg::ST_EXEC : mbf_pkg::ST_IDLE;
        end
        mbf_pkg::ST_EXEC: begin
          idx <= 9'h000;
          word_ok <= 1'b0;
          first_fetch <= 1'b1;
          kind <= mbf_pkg::K_EXC;
          body_len <= 9'h003;
          state <= mbf_pkg::ST_SEND;
          if (is_read_fc(fc)) begin
            if (rx_len != `MBF_REQ_LEN || w4 == 16'h0000 || w4 > `MBF_RD_MAX) begin
              exc_code <= `MBF_EXC_VALUE;
            end else if (w2 >= `MBF_PDO_BASE && w2[0]) begin
              exc_code <= `MBF_EXC_ADDR;
            end else begin
              kind <= mbf_pkg::K_READ;
              body_len <= {w4[7:0], 1'b0} + 9'h003;
              fetch_addr <= w2 + 16'h0001;
              o_od <= '{valid: 1'b1, op: mbf_pkg::OD_READ, addr: w2, wdata: 16'h0000};
              state <= mbf_pkg::ST_OD_WAIT;
            end
          end else if (fc == `MBF_FC_WR_SINGLE) begin
            if (rx_len != `MBF_REQ_LEN) begin
              exc_code <= `MBF_EXC_VALUE;
            end else if (w2 < `MBF_PDO_BASE) begin
              exc_code <= `MBF_EXC_ADDR;
            end else begin
              kind <= mbf_pkg::K_ECHO;
              body_len <= 9'h006;
              o_od <= '{valid: 1'b1, op: mbf_pkg::OD_WRITE, addr: w2, wdata: w4};
              state <= mbf_pkg::ST_OD_WAIT;
            end
          end else if (fc == `MBF_FC_DIAG) begin
            if (rx_len != `MBF_REQ_LEN) begin
              exc_code <= `MBF_EXC_VALUE;
            end else if (!is_diag_sub(w2)) begin
              exc_code <= `MBF_EXC_FUNC;
            end else begin
              kind <= mbf_pkg::K_DIAG;
              body_len <= 9'h006;
              word <= (w2 == `MBF_SUB_CLEAR) ? w4 : cnt[sub_off[2:0]];
            end
          end else if (fc == `MBF_FC_DUMP_DICT || fc == `MBF_FC_DUMP_ARRAY) begin
            if (hdr[2] != `MBF_SUB_START && hdr[2] != `MBF_SUB_NEXT) begin
              exc_code <= `MBF_EXC_FUNC;
            end else begin
              kind <= mbf_pkg::K_DUMP;
              fetch_addr <= 16'h0000;
              o_od <= '{valid: 1'b1, op: mbf_pkg::OD_SEG_OPEN, addr: {hdr[3], hdr[4]}, wdata: {fc, hdr[2]}};
              state <= mbf_pkg::ST_OD_WAIT;
            end
          end else begin
            exc_code <= `MBF_EXC_FUNC;
          end
          // broadcast: only a single write acts, and nothing answers
          if (bcast) begin
            kind <= mbf_pkg::K_ECHO;
            if (fc == `MBF_FC_WR_SINGLE && rx_len == `MBF_REQ_LEN && w2 >= `MBF_PDO_BASE) begin
              o_od <= '{valid: 1'b1, op: mbf_pkg::OD_WRITE, addr: w2, wdata: w4};
              state <= mbf_pkg::ST_OD_WAIT;
            end else begin
              o_od <= '0;
              state <= mbf_pkg::ST_IDLE;
            end
          end
        end
        mbf_pkg::ST_OD_WAIT: begin
          if (i_od.ack) begin
            o_od <= '0;
            first_fetch <= 1'b0;
            state <= bcast ? mbf_pkg::ST_IDLE : mbf_pkg::ST_SEND;
            if (first_fetch && i_od.exc != 8'h00) begin
              kind <= mbf_pkg::K_EXC;
              exc_code <= i_od.exc;
              body_len <= 9'h003;
            end else if (o_od.op == mbf_pkg::OD_SEG_OPEN) begin
              body_len <= {1'b0, i_od.rdata[7:0]} + 9'h004;
            end else begin
              word <= i_od.rdata;
              word_ok <= 1'b1;
            end
          end
        end
        mbf_pkg::ST_SEND: begin
          if (tx_free) begin
            if (need_word) begin
              o_tx <= '0;
              fetch_addr <= fetch_addr + 16'h0001;
              if (kind == mbf_pkg::K_DUMP) begin
                o_od <= '{valid: 1'b1, op: mbf_pkg::OD_SEG_BYTE, addr: fetch_addr, wdata: 16'h0000};
              end else begin
                o_od <= '{valid: 1'b1, op: mbf_pkg::OD_READ, addr: fetch_addr, wdata: 16'h0000};
              end
              state <= mbf_pkg::ST_OD_WAIT;
            end else if (idx == body_len) begin
              o_tx <= '{valid: 1'b1, last: 1'b0, data: tx_crc[7:0]};
              idx <= idx + 9'h001;
            end else if (idx == body_len + 9'h001) begin
              o_tx <= '{valid: 1'b1, last: 1'b1, data: tx_crc[15:8]};
              idx <= idx + 9'h001;
            end else if (in_crc) begin
              o_tx <= '0;
              state <= mbf_pkg::ST_IDLE;
            end else begin
              o_tx <= '{valid: 1'b1, last: 1'b0, data: next_byte};
              idx <= idx + 9'h001;
              if ((kind == mbf_pkg::K_READ && idx >= 9'h003 && !idx[0]) || kind == mbf_pkg::K_DUMP) begin
                word_ok <= 1'b0;
              end
            end
          end
        end
        default: state <= mbf_pkg::ST_IDLE;
      endcase
    end
  end

endmodule

// ===== tb/mbf_function_handler_asserts.sv
/*
  port checker of the modbus function handler, bound to every instance.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module mbf_function_handler_asserts (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // watched ports
  input wire logic [7:0] i_station_address_field,
  input wire mbf_pkg::mbf_rx_t i_rx,
  input wire logic i_tx_ready,
  input wire mbf_pkg::mbf_tx_t o_tx,
  input wire mbf_pkg::mbf_od_rsp_t i_od,
  input wire mbf_pkg::mbf_od_req_t o_od,
  input wire logic [15:0] o_diag_register
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic [7:0] tx_idx;
  logic [7:0] rx_pos;
  logic [7:0] req_fc;
  //////////////////////////////////////////
  // position of the byte within the reply
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      tx_idx <= 8'h00;
    end else if (o_tx.valid && i_tx_ready) begin
      tx_idx <= o_tx.last ? 8'h00 : tx_idx + 8'h01;
    end
  end
  // function code of the request being served
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      rx_pos <= 8'h00;
      req_fc <= 8'h00;
    end else if (i_rx.frame_end) begin
      rx_pos <= 8'h00;
    end else if (i_rx.valid) begin
      if (rx_pos == 8'h01) req_fc <= i_rx.data;
      if (rx_pos != 8'hff) rx_pos <= rx_pos + 8'h01;
    end
  end
  //////////////////////////////////////////
  chk_tx_byte_holds: assert property (o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx))
    else $error("reply byte changed before taken");
  chk_od_req_holds: assert property (o_od.valid && !i_od.ack |=> o_od.valid && $stable(o_od))
    else $error("dictionary request changed before ack");
  chk_od_req_drops: assert property (o_od.valid && i_od.ack |=> !o_od.valid)
    else $error("dictionary request held after ack");
  chk_reset_leaves_idle: assert property ($rose(i_reset_n) |-> !o_tx.valid && !o_od.valid && !o_diag_register)
    else $error("outputs not idle after reset");
  chk_first_is_station: assert property (o_tx.valid && tx_idx == 8'h00 |-> o_tx.data == i_station_address_field)
    else $error("reply does not open with own station");
  chk_code_echoed: assert property (o_tx.valid && tx_idx == 8'h01 |-> o_tx.data[6:0] == req_fc[6:0])
    else $error("reply code does not echo the request");
  chk_last_ends_reply: assert property (o_tx.valid && o_tx.last && i_tx_ready |=> !o_tx.valid)
    else $error("byte offered after the last");
  chk_write_to_pdo: assert property (o_od.valid && o_od.op == mbf_pkg::OD_WRITE |-> o_od.addr >= 16'h1000)
    else $error("write outside process data");
  cover property (o_od.valid && o_od.op == mbf_pkg::OD_SEG_BYTE && i_od.ack);
  cover property (o_tx.valid && tx_idx == 8'h01 && o_tx.data[7]);
  cover property (o_od.valid && o_od.op == mbf_pkg::OD_WRITE && i_od.ack);
  cover property (o_tx.valid && tx_idx == 8'h02 && o_tx.data == 8'h06);
endmodule

bind mbf_function_handler mbf_function_handler_asserts u_chk (
  .i_clock(i_clock),
  .i_reset_n(i_reset_n),
  .i_station_address_field(i_station_address_field),
  .i_rx(i_rx),
  .i_tx_ready(i_tx_ready),
  .o_tx(o_tx),
  .i_od(i_od),
  .o_od(o_od),
  .o_diag_register(o_diag_register)
);

// ===== tb/mbf_dict_model.sv
/*
  dictionary model answering the handler's requests, with varying delay.
  assumes requests held until ack, on the handler clock.
*/
`timescale 1ns/1ps

module mbf_dict_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // request and answer
  input wire mbf_pkg::mbf_od_req_t i_req,
  output mbf_pkg::mbf_od_rsp_t o_rsp
);
  logic [15:0] mem [0:65535];
  logic [1:0] wait_cnt;
  logic [1:0] pace;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rsp <= '0;
      wait_cnt <= 2'h0;
      pace <= 2'h0;
    end else if (o_rsp.ack || !i_req.valid) begin
      o_rsp.ack <= 1'b0;
      o_rsp.rdata <= ~o_rsp.rdata;
      wait_cnt <= pace;
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
    end else begin
      pace <= pace + 2'h1;
      o_rsp.ack <= 1'b1;
      // reads of 0006 and 0007 answer busy and nak
      o_rsp.exc <= (i_req.op == mbf_pkg::OD_READ && i_req.addr[15:1] == 15'h0003) ? i_req.addr[7:0] : 8'h00;
      case (i_req.op)
        mbf_pkg::OD_READ: o_rsp.rdata <= {i_req.addr[7:0], i_req.addr[15:8]} ^ 16'h5a5a;
        mbf_pkg::OD_WRITE: mem[i_req.addr] <= i_req.wdata;
        mbf_pkg::OD_SEG_OPEN: o_rsp.rdata <= 16'h0004;
        default: o_rsp.rdata <= {8'h00, i_req.addr[7:0] + 8'h30};
      endcase
    end
  end
endmodule

// ===== tb/mbf_function_handler_tb_top.sv
/*
  self-checking bench of the modbus function handler.
  assumes the dictionary model and the bound checker.
*/
`timescale 1ns/1ps

module mbf_function_handler_tb_top;
  logic i_clock;
  logic i_reset_n;
  logic [7:0] i_station_address_field;
  mbf_pkg::mbf_rx_t i_rx;
  logic i_tx_ready;
  mbf_pkg::mbf_tx_t o_tx;
  mbf_pkg::mbf_od_rsp_t i_od;
  mbf_pkg::mbf_od_req_t o_od;
  logic [15:0] o_diag_register;
  int err_total;
  int comparisons;
  int cycles;
  logic [7:0] req[$];
  logic [7:0] exp[$];
  logic [7:0] got[$];
  logic [7:0] want[8] = '{8'h05, 8'h01, 8'h03, 8'h07, 8'h00, 8'h01, 8'h01, 8'h01};

  mbf_function_handler dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_station_address_field(i_station_address_field), .i_rx(i_rx), .i_tx_ready(i_tx_ready),
    .o_tx(o_tx), .i_od(i_od), .o_od(o_od), .o_diag_register(o_diag_register));
  mbf_dict_model mdl (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_req(o_od), .o_rsp(i_od));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  //////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] wanted);
    comparisons++;
    if (seen !== wanted) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, wanted);
    end
  endtask
  task automatic add_crc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask
  task automatic push_word(input logic [15:0] a);
    logic [15:0] w;
    w = {a[7:0], a[15:8]} ^ 16'h5a5a;
    exp.push_back(w[15:8]);
    exp.push_back(w[7:0]);
  endtask
  // send req, take the reply with a stalling sink, compare with exp
  task automatic xact(input logic bad);
    int lim;
    add_crc(req);
    if (bad) req[req.size() - 1] ^= 8'h01;
    if (exp.size() > 0) add_crc(exp);
    lim = exp.size() > 0 ? 3000 : 60;
    foreach (req[i]) begin
      @(negedge i_clock);
      i_rx.valid = 1'b1;
      i_rx.data = req[i];
    end
    @(negedge i_clock);
    i_rx.valid = 1'b0;
    i_rx.frame_end = 1'b1;
    @(negedge i_clock);
    i_rx.frame_end = 1'b0;
    got.delete();
    for (int n = 0; n < lim; n++) begin
      @(negedge i_clock);
      i_tx_ready = n[0] | n[2];
      if (o_tx.valid === 1'b1 && i_tx_ready) begin
        got.push_back(o_tx.data);
        check(o_tx.last, got.size() == exp.size());
        if (o_tx.last === 1'b1) break;
      end
    end
    @(negedge i_clock);
    i_tx_ready = 1'b0;
    check(16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < got.size()) check(got[i], exp[i]);
    req.delete();
    exp.delete();
  endtask
  //////////////////////////////////////////
  task automatic t_diag();
    req = '{8'h05, 8'h08, 8'h00, 8'h0a, 8'h12, 8'h34};
    exp = req;
    xact(1'b0);
    req = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    xact(1'b1);
    @(negedge i_clock);
    i_rx.overrun = 1'b1;
    @(negedge i_clock);
    i_rx.overrun = 1'b0;
    req = '{8'h05, 8'h07};
    exp = '{8'h05, 8'h87, 8'h01};
    xact(1'b0);
    check(o_diag_register, 16'h0002);
    for (int e = 6; e < 8; e++) begin
      req = '{8'h05, 8'h03, 8'h00, 8'(e), 8'h00, 8'h01};
      exp = '{8'h05, 8'h83, 8'(e)};
      xact(1'b0);
    end
    check(o_diag_register, 16'h00c2);
    for (int s = 0; s < 8; s++) begin
      req = '{8'h05, 8'h08, 8'h00, 8'h0b + 8'(s), 8'h00, 8'h00};
      exp = '{8'h05, 8'h08, 8'h00, 8'h0b + 8'(s), 8'h00, want[s]};
      xact(1'b0);
    end
    req = '{8'h05, 8'h08, 8'h00, 8'h0a, 8'h00, 8'h00};
    exp = req;
    xact(1'b0);
    check(o_diag_register, 16'h0000);
  endtask
  task automatic t_read();
    req = '{8'h05, 8'h03, 8'h13, 8'h88, 8'h00, 8'h02};
    exp = '{8'h05, 8'h03, 8'h04};
    push_word(16'h1388);
    push_word(16'h1389);
    xact(1'b0);
    req = '{8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h7d};
    exp = '{8'h05, 8'h04, 8'hfa};
    for (int i = 0; i < 125; i++) push_word(16'(i));
    xact(1'b0);
    req = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    exp = '{8'h05, 8'h83, 8'h03};
    xact(1'b0);
    req = '{8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h7e};
    exp = '{8'h05, 8'h84, 8'h03};
    xact(1'b0);
    req = '{8'h05, 8'h03, 8'h10, 8'h01, 8'h00, 8'h01};
    exp = '{8'h05, 8'h83, 8'h02};
    xact(1'b0);
  endtask
  task automatic t_write();
    req = '{8'h05, 8'h06, 8'h17, 8'h70, 8'h00, 8'h01};
    exp = req;
    xact(1'b0);
    check(mdl.mem[16'h1770], 16'h0001);
    req = '{8'h05, 8'h06, 8'h01, 8'h00, 8'hff, 8'hff};
    exp = '{8'h05, 8'h86, 8'h02};
    xact(1'b0);
    req = '{8'h00, 8'h06, 8'h17, 8'h72, 8'hbe, 8'hef};
    xact(1'b0);
    check(mdl.mem[16'h1772], 16'hbeef);
    req = '{8'h05, 8'h08, 8'h00, 8'h0f, 8'h00, 8'h00};
    exp = '{8'h05, 8'h08, 8'h00, 8'h0f, 8'h00, 8'h01};
    xact(1'b0);
  endtask
  task automatic t_dump();
    logic [7:0] fc;
    for (int f = 0; f < 2; f++) begin
      fc = 8'h65 + 8'(f);
      foreach (want[s]) if (s < 2) begin
        req = '{8'h05, fc, s ? 8'haa : 8'h55, 8'h10, 8'h00};
        exp = '{8'h05, fc, s ? 8'haa : 8'h55, 8'h04, 8'h30, 8'h31, 8'h32, 8'h33};
        xact(1'b0);
      end
      req = '{8'h05, fc, 8'h77, 8'h10, 8'h00};
      exp = '{8'h05, fc | 8'h80, 8'h01};
      xact(1'b0);
    end
  endtask
  //////////////////////////////////////////
  initial begin
    i_reset_n = 1'b0;
    i_station_address_field = 8'h05;
    i_rx = '0;
    i_tx_ready = 1'b0;
    repeat (16) @(negedge i_clock);
    i_reset_n = 1'b1;
    t_diag();
    t_read();
    t_write();
    t_dump();
    i_reset_n = 1'b0;
    @(negedge i_clock);
    i_reset_n = 1'b1;
    req = '{8'h05, 8'h08, 8'h00, 8'h0b, 8'h00, 8'h00};
    exp = '{8'h05, 8'h08, 8'h00, 8'h0b, 8'h00, 8'h01};
    xact(1'b0);
    report_and_stop();
  end
endmodule
